// ### dv/host_strap_model.sv
// host-side model: sets the straps, then pulses sync
`timescale 1ns/10ps
module host_strap_model
  import strap_cfg_pkg::*;
(
  // clock and request from the bench
  input  wire logic                  aclk,
  input  wire strap_cfg_pkg::strap_t req,
  input  wire logic                  go,
  input  wire logic                  with_sync,
  // pins toward the device
  output wire strap_cfg_pkg::strap_t strap_pins,
  output wire logic                  sync_in_pin
);
  logic [2:0] cnt_r  = 3'h0;
  strap_t     pins_r = '0;
  // straps move first so they are stable before sync arrives
  always @(posedge aclk) begin
    if (go) begin
      pins_r     <= req;
      cnt_r      <= with_sync ? 3'h6 : 3'h0;
    end else if (cnt_r != 3'h0) begin
      cnt_r <= cnt_r - 3'h1;
    end
  end
  assign strap_pins  = pins_r;
  assign sync_in_pin = (cnt_r != 3'h0) && (cnt_r < 3'h4);
endmodule : host_strap_model

// ### dv/pin_strap_config_decoder_bench.sv
// self-checking bench for the strap configuration decoder
`timescale 1ns/10ps
module pin_strap_config_decoder_bench;
  import strap_cfg_pkg::*;
  logic aclk, aresetn, go, with_sync, sample_valid, crc_err, os, sync_in_pin;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, pin_ctrl_mode, cfg_apply, slot_valid;
  logic common_mode_out_en, xtal_drive_en, irq;
  logic mem_bit_flip, clk_missing, flt;
  logic [3:0]   s_axi_awaddr, s_axi_araddr, data_clock_divider, c;
  logic [1:0]   s_axi_bresp, s_axi_rresp, rsp, pm, dc;
  logic [31:0]  s_axi_wdata, s_axi_rdata, rd;
  logic [191:0] conv_data;
  logic [255:0] slot_data;
  logic [7:0]   filt_unsettled, filt_saturated, chan_standby, sb;
  logic [10:0]  decim_value;
  logic [5:0]   modulator_div;
  strap_t       req, strap_pins;
  cfg_t         active_cfg;
  int           error_cnt = 0;
  int           compares = 0;
  int           n;

  pin_strap_config_decoder #(.NUM_CH(8)) pin_strap_config_decoder_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .strap_pins, .sync_in_pin, .sample_valid,
    .conv_data, .filt_unsettled, .filt_saturated, .crc_err,
    .mem_bit_flip, .clk_missing, .pin_ctrl_mode, .active_cfg,
    .decim_value, .modulator_div, .data_clock_divider, .chan_standby,
    .common_mode_out_en, .xtal_drive_en, .cfg_apply, .slot_data,
    .slot_valid, .irq);
  host_strap_model host_strap_model_inst (.aclk, .req, .go, .with_sync,
    .strap_pins, .sync_in_pin);

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  // one bus access; each channel released at its own handshake edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    // only raise this access's own channels; the others stay released
    if (w) begin
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    while (k < 50) begin
      @(posedge aclk);
      k++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid) begin
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        k = 99;
      end
      if (s_axi_rready && s_axi_rvalid) begin
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        k = 99;
      end
    end
    if (k != 99) error_cnt++;
  endtask : bus
  // bounded wait for a capture, then let derived outputs settle
  task automatic wapp;
    n = 0;
    while (cfg_apply !== 1'b1 && n < 40) begin
      @(posedge aclk);
      n++;
    end
    repeat (2) @(posedge aclk);
  endtask : wapp
  task automatic cap(input strap_t s, input logic sy);
    req <= s;
    with_sync <= sy;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    wapp();
    chk(32'(n < 40), 32'(sy));
  endtask : cap

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // hang guard, well beyond the expected run length
  initial begin
    repeat (5000) @(posedge aclk);
    error_cnt++;
    close_out();
  end

  initial begin
    {aresetn, go, with_sync, sample_valid, crc_err, s_axi_awvalid} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {req, conv_data, filt_unsettled, filt_saturated} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {mem_bit_flip, clk_missing} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({decim_value, modulator_div, data_clock_divider}, {11'h400, 6'h20, 4'h8});
    wapp();
    chk(pin_ctrl_mode, 1'b1);
    bus(1'b1, ADDR_IRQ_MASK, 32'h0000_0002);
    // every op code, with decimation, filter and standby straps cycling
    for (int i = 0; i < 16; i++) begin
      c = 4'(i);
      cap({c[0], c[2:1], c, c[3:2], 1'b0}, 1'b1);
      os = c >= 4'hC;
      pm = c[3:2];
      dc = c[1:0];
      if (os) pm = (c[1:0] == 2'h0) ? 2'h0 : (c[1:0] == 2'h1) ? 2'h1 : 2'h2;
      if (os) dc = {1'b0, c[1:0] == 2'h2};
      sb = {{4{c[3]}}, {4{c[2]}}};
      bus(1'b0, ADDR_CONFIG, 32'h0);
      chk(rd, {8'h0, sb, 7'h0, os, dc, pm, c[2:1], c[0], 1'b1});
      chk(modulator_div, pm == 2'h2 ? 6'h4 : pm == 2'h1 ? 6'h8 : 6'h20);
      chk(data_clock_divider, 4'h1 << dc);
      chk(32'(32 * data_clock_divider <= modulator_div * decim_value), 1);
      chk(decim_value, c[2:1] == 2'h3 ? 11'h400 : 11'h20 << c[2:1]);
      chk({common_mode_out_en, xtal_drive_en}, {!sb[0], !sb[4]});
      sample_valid <= 1'b1;
      crc_err <= (c == 4'h5);
      mem_bit_flip <= (c == 4'h9);
      clk_missing <= (c == 4'hA);
      flt = (c == 4'h5) || (c == 4'h9) || (c == 4'hA);
      filt_unsettled <= {c, ~c};
      filt_saturated <= {~c, c};
      conv_data <= {24{c, 4'h9}};
      @(posedge aclk);
      sample_valid <= 1'b0;
      @(posedge aclk);
      chk(slot_valid, 1'b1);
      for (int k = 0; k < 8; k++) begin
        chk(slot_data[k*32+:32], sb[k] ? 32'h0 : {flt, filt_unsettled[k],
          c[0], filt_saturated[k], 4'h0, conv_data[k*24+:24]});
      end
      chk(irq, c >= 4'h5);
      $display("test %0d done", i);
    end
    bus(1'b1, ADDR_IRQ_STAT, 32'h0000_0002);
    @(posedge aclk);
    chk(irq, 1'b0);
    bus(1'b1, ADDR_CONFIG, 32'h0);
    chk(rsp, RESP_SLVERR);
    bus(1'b0, ADDR_CONTROL, 32'h0);
    chk(rd, 32'h0);
    // straps moved without sync must not reach the active settings
    cap('0, 1'b0);
    chk(active_cfg, {1'b1, 2'h3, 2'h2, 2'h0, 1'b1});
    bus(1'b1, ADDR_CONTROL, 32'h0000_0001);
    wapp();
    chk(active_cfg, 7'h00);
    // loaded and strap-moved flags stay sticky; fault was cleared above
    bus(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(rd, 32'h0000_0005);
    chk(rsp, RESP_OKAY);
    $display("test sync done");
    close_out();
  end
endmodule : pin_strap_config_decoder_bench

// ### rtl/pin_strap_config_decoder.sv
// strap capture, configuration decode, slot zeroing and register slave
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps

module pin_strap_config_decoder
  import strap_cfg_pkg::*;
#(
  parameter int NUM_CH = 8
) (
  // clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // axi4-lite register slave
  input  wire logic [3:0]                    s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output      logic                          s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output      logic                          s_axi_wready,
  output      logic [1:0]                    s_axi_bresp,
  output      logic                          s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [3:0]                    s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output      logic                          s_axi_arready,
  output      logic [31:0]                   s_axi_rdata,
  output      logic [1:0]                    s_axi_rresp,
  output      logic                          s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // strap pins and sync pin (asynchronous)
  input  wire strap_cfg_pkg::strap_t         strap_pins,
  input  wire logic                          sync_in_pin,
  // conversion results from the channel cores
  input  wire logic                          sample_valid,
  input  wire logic [NUM_CH*24-1:0]          conv_data,
  input  wire logic [NUM_CH-1:0]             filt_unsettled,
  input  wire logic [NUM_CH-1:0]             filt_saturated,
  input  wire logic                          crc_err,
  input  wire logic                          mem_bit_flip,
  input  wire logic                          clk_missing,
  // decoded configuration
  output      logic                          pin_ctrl_mode,
  output      strap_cfg_pkg::cfg_t           active_cfg,
  output      logic [10:0]                   decim_value,
  output      logic [5:0]                    modulator_div,
  output      logic [3:0]                    data_clock_divider,
  output      logic [NUM_CH-1:0]             chan_standby,
  output      logic                          common_mode_out_en,
  output      logic                          xtal_drive_en,
  output      logic                          cfg_apply,
  // output slots, header in the top byte of each word
  output      logic [NUM_CH*32-1:0]          slot_data,
  output      logic                          slot_valid,
  // interrupt
  output      logic                          irq
);

  localparam int XTAL_CH = (NUM_CH == 8) ? 4 : 2;

  typedef struct packed {
    strap_t                 s1;
    strap_t                 s2;
    logic                   sy1;
    logic                   sy2;
    logic                   sy3;
    logic [1:0]             boot_cnt;
    logic                   pin_mode;
    strap_t                 cap;
    cfg_t                   cfg;
    logic [10:0]            decim;
    logic [5:0]             mdiv;
    logic [3:0]             ddiv;
    logic [NUM_CH-1:0]      stby;
    logic                   cm_en;
    logic                   xt_en;
    logic                   apply;
    logic [NUM_CH*32-1:0]   slot;
    logic                   slot_v;
    logic [IRQ_W-1:0]       irq_stat;
    logic [IRQ_W-1:0]       irq_mask;
    logic                   soft_sync;
    logic                   aw_have;
    logic                   w_have;
    logic [3:0]             awaddr;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
  } state_t;

  state_t state_r;
  state_t state_nxt;
  logic   load_now;
  logic   boot_load;

  // ****************************************
  // helpers
  // ****************************************
  // bank standby decode; the small part has one strap and one bank
  function automatic logic [NUM_CH-1:0] standby_decode(input strap_t s);
    logic [7:0] b;
    b = {{4{s.standby_bank_sel_hi}}, {4{s.standby_bank_sel_lo}}};
    if (NUM_CH != 8) begin
      b = {4'h0, {4{s.standby_bank_sel_lo}}};
    end
    return b[NUM_CH-1:0];
  endfunction : standby_decode

  function automatic logic [31:0] read_word(input logic [3:0] a,
                                            input state_t st);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      ADDR_CONFIG: begin
        w[CFGW_PIN_MODE]        = st.pin_mode;
        w[CFGW_SINC5]           = st.cfg.sinc5;
        w[CFGW_DECIM +: 2]      = st.cfg.decim_code;
        w[CFGW_PWR +: 2]        = st.cfg.op.pm;
        w[CFGW_SERIAL_DATA_CLOCK +: 2]       = st.cfg.op.serial_data_clock_code;
        w[CFGW_ONE_SHOT]        = st.cfg.op.one_shot;
        w[CFGW_STANDBY +: NUM_CH] = st.stby;
      end
      ADDR_IRQ_STAT: w[IRQ_W-1:0] = st.irq_stat;
      ADDR_IRQ_MASK: w[IRQ_W-1:0] = st.irq_mask;
      default:       w = 32'h0000_0000;
    endcase
    return w;
  endfunction : read_word

  function automatic logic mapped(input logic [3:0] a);
    return (a == ADDR_CONFIG) || (a == ADDR_CONTROL) ||
           (a == ADDR_IRQ_STAT) || (a == ADDR_IRQ_MASK);
  endfunction : mapped

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    logic          wr_go;
    logic          fault;
    logic [IRQ_W-1:0] ev;
    op_dec_t       od;
    state_nxt = state_r;
    wr_go     = 1'b0;
    fault     = 1'b0;
    ev        = '0;
    od        = decode_op({state_r.s2.op_code_bit3, state_r.s2.op_code_bit2,
                           state_r.s2.op_code_bit1, state_r.s2.op_code_bit0});

    // two-stage strap synchroniser feeding logic from stage two; sync has a third stage for edge detection
    state_nxt.s1  = strap_pins;
    state_nxt.s2  = state_r.s1;
    state_nxt.sy1 = sync_in_pin;
    state_nxt.sy2 = state_r.sy1;
    state_nxt.sy3 = state_r.sy2;

    // boot wait lets the synchronisers fill before the first capture
    boot_load = (state_r.boot_cnt == 2'h1);
    if (state_r.boot_cnt != 2'h0) begin
      state_nxt.boot_cnt = state_r.boot_cnt - 2'h1;
    end
    if (boot_load) begin
      state_nxt.pin_mode = !state_r.s2.ctrl_mode_spi;
    end

    // capture only on boot or sync so strap glitches never leak in
    load_now = boot_load || (state_r.sy2 && !state_r.sy3) ||
               state_r.soft_sync;
    state_nxt.soft_sync = 1'b0;
    state_nxt.apply     = load_now;
    if (load_now) begin
      state_nxt.cap = state_r.s2;
      ev[IRQ_LOADED] = 1'b1;
      if ((boot_load && !state_r.s2.ctrl_mode_spi) ||
          (!boot_load && state_r.pin_mode)) begin
        state_nxt.cfg.sinc5      = state_r.s2.filter_sel;
        state_nxt.cfg.decim_code = {state_r.s2.decim_sel_hi,
                                    state_r.s2.decim_sel_lo};
        state_nxt.cfg.op         = od;
        state_nxt.stby           = standby_decode(state_r.s2);
      end else begin
        state_nxt.cfg  = CFG_RESET;
        state_nxt.stby = '0;
      end
    end
    // strap movement without a sync is reported, not applied
    if (state_r.pin_mode && (state_r.s2 != state_r.cap) &&
        (state_r.boot_cnt == 2'h0)) begin
      ev[IRQ_STRAP_CHG] = 1'b1;
    end

    // derived rates follow the decimation, power mode and data clock fields
    state_nxt.decim = decim_ratio(state_nxt.cfg.decim_code);
    state_nxt.mdiv  = mod_div(state_nxt.cfg.op.pm);
    state_nxt.ddiv  = 4'h1 << state_nxt.cfg.op.serial_data_clock_code;
    state_nxt.cm_en = !state_nxt.stby[0];
    state_nxt.xt_en = !state_nxt.stby[XTAL_CH];

    // slot assembly; standby slots stay in place but read as zero
    state_nxt.slot_v = sample_valid;
    if (sample_valid) begin
      fault = crc_err || mem_bit_flip || clk_missing;
      for (int c = 0; c < NUM_CH; c++) begin
        logic [7:0] hdr;
        hdr                 = 8'h00;
        hdr[HDR_ERR]        = fault;
        hdr[HDR_UNSETTLED]  = filt_unsettled[c];
        hdr[HDR_FILT_SINC5] = state_r.cfg.sinc5;
        hdr[HDR_SATURATED]  = filt_saturated[c];
        state_nxt.slot[c*32 +: 32] = state_r.stby[c] ? 32'h0000_0000 :
          {hdr, conv_data[c*24 +: 24]};
      end
      ev[IRQ_FAULT] = fault;
    end

    // axi write: address and data may arrive in either order
    if (s_axi_awvalid && !state_r.aw_have && !state_r.bvalid) begin
      state_nxt.aw_have = 1'b1;
      state_nxt.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state_r.w_have && !state_r.bvalid) begin
      state_nxt.w_have = 1'b1;
      state_nxt.wdata  = s_axi_wdata;
      state_nxt.wstrb  = s_axi_wstrb;
    end
    if (state_r.aw_have && state_r.w_have) begin
      wr_go             = 1'b1;
      state_nxt.aw_have = 1'b0;
      state_nxt.w_have  = 1'b0;
      state_nxt.bvalid  = 1'b1;
      state_nxt.bresp   = (mapped(state_r.awaddr) &&
                           state_r.awaddr != ADDR_CONFIG) ?
                          RESP_OKAY : RESP_SLVERR;
    end
    if (state_r.bvalid && s_axi_bready) begin
      state_nxt.bvalid = 1'b0;
    end

    // interrupt status: hardware set wins over write-one-to-clear
    if (wr_go && state_r.wstrb[0]) begin
      unique case (state_r.awaddr)
        ADDR_CONTROL:
          state_nxt.soft_sync = state_r.wdata[CTRL_SYNC_BIT];
        ADDR_IRQ_STAT:
          state_nxt.irq_stat = state_r.irq_stat &
                               ~state_r.wdata[IRQ_W-1:0];
        ADDR_IRQ_MASK:
          state_nxt.irq_mask = state_r.wdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    state_nxt.irq_stat = state_nxt.irq_stat | ev;

    // axi read: one cycle from address to data
    if (s_axi_arvalid && !state_r.rvalid) begin
      state_nxt.rvalid = 1'b1;
      state_nxt.rdata  = read_word(s_axi_araddr, state_r);
      state_nxt.rresp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (state_r.rvalid && s_axi_rready) begin
      state_nxt.rvalid = 1'b0;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r          <= '0;
      state_r.boot_cnt <= BOOT_SETTLE + 2'h1;
      state_r.cfg      <= CFG_RESET;
      state_r.decim    <= DECIM_X1024;
      state_r.mdiv     <= MOD_DIV_LOW;
      state_r.ddiv     <= 4'h8;
      state_r.cm_en    <= 1'b1;
      state_r.xt_en    <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  // outputs
  assign s_axi_awready      = !state_r.aw_have && !state_r.bvalid;
  assign s_axi_wready       = !state_r.w_have && !state_r.bvalid;
  assign s_axi_bvalid       = state_r.bvalid;
  assign s_axi_bresp        = state_r.bresp;
  assign s_axi_arready      = !state_r.rvalid;
  assign s_axi_rvalid       = state_r.rvalid;
  assign s_axi_rdata        = state_r.rdata;
  assign s_axi_rresp        = state_r.rresp;
  assign pin_ctrl_mode      = state_r.pin_mode;
  assign active_cfg         = state_r.cfg;
  assign decim_value        = state_r.decim;
  assign modulator_div      = state_r.mdiv;
  assign data_clock_divider = state_r.ddiv;
  assign chan_standby       = state_r.stby;
  assign common_mode_out_en = state_r.cm_en;
  assign xtal_drive_en      = state_r.xt_en;
  assign cfg_apply          = state_r.apply;
  assign slot_data          = state_r.slot;
  assign slot_valid         = state_r.slot_v;
  assign irq                = |(state_r.irq_stat & state_r.irq_mask);

  // ****************************************
  // assertions
  // ****************************************
  property p_filter_load;
    @(posedge aclk) disable iff (!aresetn)
    load_now && state_r.pin_mode && !boot_load
      |=> active_cfg.sinc5 == $past(state_r.s2.filter_sel);
  endproperty
  a_filter_load: assert property (p_filter_load)
    else $error("filter type not taken from strap");

  property p_decim_map;
    @(posedge aclk) disable iff (!aresetn)
    (active_cfg.decim_code == 2'h3 |-> decim_value == 11'h400) and
    (active_cfg.decim_code == 2'h0 |-> decim_value == 11'h020);
  endproperty
  a_decim_map: assert property (p_decim_map)
    else $error("decimation ratio mismatch");

  property p_std_mode;
    @(posedge aclk) disable iff (!aresetn)
    load_now && state_r.pin_mode && !state_r.s2.op_code_bit3
      && state_r.s2.op_code_bit2 && state_r.s2.op_code_bit1
      |=> !active_cfg.op.one_shot && active_cfg.op.pm == pm_median
      ##1 data_clock_divider >= 4'h4;
  endproperty
  a_std_mode: assert property (p_std_mode)
    else $error("standard mode decode wrong");

  property p_one_shot_e;
    @(posedge aclk) disable iff (!aresetn)
    load_now && state_r.pin_mode && state_r.s2.op_code_bit3 &&
      state_r.s2.op_code_bit2 && state_r.s2.op_code_bit1 &&
      !state_r.s2.op_code_bit0
      |=> active_cfg.op.one_shot ##1 data_clock_divider == 4'h2;
  endproperty
  a_one_shot_e: assert property (p_one_shot_e)
    else $error("one-shot code 0xE decode wrong");

  property p_mod_fast;
    @(posedge aclk) disable iff (!aresetn)
    $changed(active_cfg.op.pm) && active_cfg.op.pm == pm_fast
      |-> modulator_div == 6'h04;
  endproperty
  a_mod_fast: assert property (p_mod_fast)
    else $error("fast modulator divide not 4");

  property p_bank_lo;
    @(posedge aclk) disable iff (!aresetn)
    load_now && state_r.pin_mode && !boot_load && NUM_CH == 8 &&
      !state_r.s2.standby_bank_sel_hi && state_r.s2.standby_bank_sel_lo
      |=> chan_standby[3:0] == 4'hF ##1 !common_mode_out_en;
  endproperty
  a_bank_lo: assert property (p_bank_lo)
    else $error("bank 0-3 standby decode wrong");

  property p_zero_slot;
    @(posedge aclk) disable iff (!aresetn)
    sample_valid && chan_standby[0]
      |=> slot_valid && slot_data[31:0] == 32'h0000_0000;
  endproperty
  a_zero_slot: assert property (p_zero_slot)
    else $error("standby slot not zero");

  property p_err_flag;
    @(posedge aclk) disable iff (!aresetn)
    sample_valid && crc_err && !chan_standby[0] |=> slot_data[31];
  endproperty
  a_err_flag: assert property (p_err_flag)
    else $error("header error bit not set");

  property p_xtal;
    @(posedge aclk) disable iff (!aresetn)
    $rose(chan_standby[XTAL_CH]) |=> !xtal_drive_en;
  endproperty
  a_xtal: assert property (p_xtal)
    else $error("crystal drive left on in standby");

  property p_hold_cfg;
    @(posedge aclk) disable iff (!aresetn)
    !load_now |=> $stable(active_cfg) && $stable(chan_standby);
  endproperty
  a_hold_cfg: assert property (p_hold_cfg)
    else $error("configuration changed without sync");

endmodule : pin_strap_config_decoder

// ### rtl/strap_cfg_pkg.sv
// constants, types and decode functions for the strap configuration decoder
package strap_cfg_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam int         ADDR_W          = 4;
  localparam logic [3:0] ADDR_CONFIG     = 4'h0;
  localparam logic [3:0] ADDR_CONTROL    = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STAT   = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK   = 4'hC;
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;

  // config word fields
  localparam int CFGW_PIN_MODE   = 0;
  localparam int CFGW_SINC5      = 1;
  localparam int CFGW_DECIM      = 2;
  localparam int CFGW_PWR        = 4;
  localparam int CFGW_SERIAL_DATA_CLOCK       = 6;
  localparam int CFGW_ONE_SHOT   = 8;
  localparam int CFGW_STANDBY    = 16;
  localparam int CTRL_SYNC_BIT   = 0;

  // interrupt bits
  localparam int IRQ_W           = 3;
  localparam int IRQ_LOADED      = 0;
  localparam int IRQ_FAULT       = 1;
  localparam int IRQ_STRAP_CHG   = 2;

  // status header bit positions
  localparam int HDR_ERR         = 7;
  localparam int HDR_UNSETTLED   = 6;
  localparam int HDR_FILT_SINC5  = 5;
  localparam int HDR_SATURATED   = 4;

  // cycles after reset release before the straps are captured
  localparam logic [1:0] BOOT_SETTLE = 2'h2;

  // ****************************************
  // encodings
  // ****************************************
  localparam logic [10:0] DECIM_X32   = 11'h020;
  localparam logic [10:0] DECIM_X64   = 11'h040;
  localparam logic [10:0] DECIM_X128  = 11'h080;
  localparam logic [10:0] DECIM_X1024 = 11'h400;
  localparam logic [5:0]  MOD_DIV_FAST = 6'h04;
  localparam logic [5:0]  MOD_DIV_MED  = 6'h08;
  localparam logic [5:0]  MOD_DIV_LOW  = 6'h20;
  localparam logic [3:0]  OP_ONE_SHOT  = 4'hC;

  typedef enum logic [1:0] {pm_low, pm_median, pm_fast} power_mode_t;

  typedef struct packed {
    logic filter_sel;
    logic decim_sel_hi;
    logic decim_sel_lo;
    logic op_code_bit3;
    logic op_code_bit2;
    logic op_code_bit1;
    logic op_code_bit0;
    logic standby_bank_sel_hi;
    logic standby_bank_sel_lo;
    logic ctrl_mode_spi;
  } strap_t;

  typedef struct packed {
    power_mode_t pm;
    logic [1:0]  serial_data_clock_code;
    logic        one_shot;
  } op_dec_t;

  typedef struct packed {
    logic       sinc5;
    logic [1:0] decim_code;
    op_dec_t    op;
  } cfg_t;

  // defaults held while the register interface owns the device
  localparam cfg_t CFG_RESET = '{sinc5: 1'b1, decim_code: 2'h3,
    op: '{pm: pm_low, serial_data_clock_code: 2'h3, one_shot: 1'b0}};

  function automatic op_dec_t decode_op(input logic [3:0] code);
    op_dec_t d;
    d = '{pm: pm_low, serial_data_clock_code: code[1:0], one_shot: 1'b0};
    if (code < OP_ONE_SHOT) begin
      d.pm = (code[3:2] == 2'h0) ? pm_low :
             (code[3:2] == 2'h1) ? pm_median : pm_fast;
    end else begin
      d.one_shot = 1'b1;
      unique case (code[1:0])
        2'h0: d = '{pm: pm_low,    serial_data_clock_code: 2'h0, one_shot: 1'b1};
        2'h1: d = '{pm: pm_median, serial_data_clock_code: 2'h0, one_shot: 1'b1};
        2'h2: d = '{pm: pm_fast,   serial_data_clock_code: 2'h1, one_shot: 1'b1};
        2'h3: d = '{pm: pm_fast,   serial_data_clock_code: 2'h0, one_shot: 1'b1};
      endcase
    end
    return d;
  endfunction : decode_op

  function automatic logic [10:0] decim_ratio(input logic [1:0] code);
    unique case (code)
      2'h0: return DECIM_X32;
      2'h1: return DECIM_X64;
      2'h2: return DECIM_X128;
      2'h3: return DECIM_X1024;
    endcase
  endfunction : decim_ratio

  function automatic logic [5:0] mod_div(input power_mode_t pm);
    unique case (pm)
      pm_fast:   return MOD_DIV_FAST;
      pm_median: return MOD_DIV_MED;
      default:   return MOD_DIV_LOW;
    endcase
  endfunction : mod_div

endpackage : strap_cfg_pkg
